// >>> core/ast_pkg.sv
package ast_pkg;

  // frame geometry
  localparam int FRAME_BITS_8 = 10;
  localparam int FRAME_BITS_9 = 11;
  localparam int DIV_WIDTH = 13;
  localparam int RT_PER_BIT = 16;

  // receiver sample points within a bit, counted from 1
  localparam logic [3:0] RT_START_A = 4'h3;
  localparam logic [3:0] RT_START_B = 4'h5;
  localparam logic [3:0] RT_START_C = 4'h7;
  localparam logic [3:0] RT_DATA_A = 4'h8;
  localparam logic [3:0] RT_DATA_B = 4'h9;
  localparam logic [3:0] RT_DATA_C = 4'hA;
  localparam logic [3:0] RT_LAST = 4'hF;

  // values after reset
  localparam logic RST_TX_EMPTY = 1'b1;
  localparam logic RST_TX_DONE = 1'b1;
  localparam logic RST_LINE = 1'b1;
  localparam logic [DIV_WIDTH-1:0] RST_BAUD_COUNT = 13'h0000;
  localparam logic [10:0] RST_SHIFT = 11'h7FF;

  typedef struct packed {
    logic charLen9;
    logic parityEn;
    logic parityOdd;
  } ast_cfg_t;

  typedef struct packed {
    logic fe;
    logic pe;
    logic nf;
    logic ninth;
    logic [7:0] data;
  } ast_rx_word_t;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SHIFT
  } ast_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } ast_rx_state_t;

endpackage

// >>> core/ast_baud_gen.sv
`timescale 1ns/1ps
module ast_baud_gen #(
  parameter int DIV_W = ast_pkg::DIV_WIDTH
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [DIV_W-1:0] divisor,
  output logic rtTick,
  output logic txTick
);

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic [3:0] rtCount;
  logic [3:0] next_rtCount;
  logic next_rtTick;
  logic next_txTick;

  // ---------------------------------------------
  // modulus counter, zero divisor stops the clock
  // ---------------------------------------------
  always_comb begin
    next_count = count;
    next_rtCount = rtCount;
    next_rtTick = 1'b0;
    next_txTick = 1'b0;
    if (divisor == '0) begin
      next_count = ast_pkg::RST_BAUD_COUNT;
    end else if (count <= DIV_W'(1)) begin
      next_count = divisor;
      next_rtTick = 1'b1;
      next_rtCount = rtCount + 4'h1;
      next_txTick = (rtCount == ast_pkg::RT_LAST);
    end else begin
      next_count = count - DIV_W'(1);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count <= ast_pkg::RST_BAUD_COUNT;
      rtCount <= 4'h0;
      rtTick <= 1'b0;
      txTick <= 1'b0;
    end else begin
      count <= next_count;
      rtCount <= next_rtCount;
      rtTick <= next_rtTick;
      txTick <= next_txTick;
    end
  end

endmodule

// >>> core/ast_skid_buf.sv
`timescale 1ns/1ps
module ast_skid_buf #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0] fill;
  logic [PW-1:0] next_wrPtr;
  logic [PW-1:0] next_rdPtr;
  logic [PW:0] next_fill;
  logic push;
  logic pop;

  // -----------------
  // pointer bookkeeping
  // -----------------
  always_comb begin
    push = inValid && inReady;
    pop = outValid && outReady;
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_fill = fill;
    if (push) begin
      next_wrPtr = (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + PW'(1);
    end
    if (pop) begin
      next_rdPtr = (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + PW'(1);
    end
    if (push && !pop) begin
      next_fill = fill + (PW+1)'(1);
    end else if (pop && !push) begin
      next_fill = fill - (PW+1)'(1);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      fill <= next_fill;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  assign inReady = (fill != (PW+1)'(DEPTH));
  assign outValid = (fill != '0);
  assign outData = mem[rdPtr];

endmodule

// >>> core/ast_transceiver.sv
`timescale 1ns/1ps
module ast_transceiver #(
  parameter int DIV_W = ast_pkg::DIV_WIDTH
) (
  input wire logic clock,
  input wire logic nrst,
  input wire ast_pkg::ast_cfg_t cfg,
  input wire logic [DIV_W-1:0] baudDivisor,
  input wire logic txEnable,
  input wire logic sendBreak,
  input wire logic txEmptyIrqEn,
  input wire logic rxFullIrqEn,
  input wire logic statusRead,
  input wire logic dataLowWrite,
  input wire logic dataHighWrite,
  input wire logic dataLowRead,
  input wire logic [7:0] txDataIn,
  input wire logic txNinthIn,
  input wire logic rxdIn,
  output logic txdOut,
  output logic txdOeN,
  output logic rxPinOwned,
  output logic txBufferEmptyFlag,
  output logic txCompleteFlag,
  output logic rxFullFlag,
  output logic framingErrFlag,
  output logic parityErrFlag,
  output logic noiseFlag,
  output logic overrunFlag,
  output logic rxActiveFlag,
  output logic [7:0] rxData,
  output logic rxNinthBit,
  output logic txIrq,
  output logic rxIrq
);

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic noisy3(input logic [2:0] s);
    noisy3 = !((s == 3'h0) || (s == 3'h7));
  endfunction

  logic rtTick;
  logic txTick;

  ast_baud_gen #(.DIV_W(DIV_W)) baudGen (
    .clock(clock),
    .nrst(nrst),
    .divisor(baudDivisor),
    .rtTick(rtTick),
    .txTick(txTick)
  );

  // ---------------------------------------------
  // transmit data register and empty flag
  // ---------------------------------------------
  logic [7:0] txData;
  logic txNinthBit;
  logic txArm;
  logic [7:0] next_txData;
  logic next_txNinthBit;
  logic next_txArm;
  logic next_txBufferEmptyFlag;
  logic txHandOver;

  always_comb begin
    next_txData = txData;
    next_txNinthBit = txNinthBit;
    next_txArm = txArm;
    next_txBufferEmptyFlag = txBufferEmptyFlag;
    if (statusRead && txBufferEmptyFlag) begin
      next_txArm = 1'b1;
    end
    if (dataHighWrite) begin
      next_txNinthBit = txNinthIn;
    end
    if (dataLowWrite) begin
      next_txData = txDataIn;
      next_txArm = 1'b0;
      if (txArm) begin
        next_txBufferEmptyFlag = 1'b0;
      end
    end
    if (txHandOver) begin
      next_txBufferEmptyFlag = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      txData <= 8'h00;
      txNinthBit <= 1'b0;
      txArm <= 1'b0;
      txBufferEmptyFlag <= ast_pkg::RST_TX_EMPTY;
    end else begin
      txData <= next_txData;
      txNinthBit <= next_txNinthBit;
      txArm <= next_txArm;
      txBufferEmptyFlag <= next_txBufferEmptyFlag;
    end
  end

  // ---------------------------------------------
  // transmit shifter
  // ---------------------------------------------
  ast_pkg::ast_tx_state_t txState;
  ast_pkg::ast_tx_state_t next_txState;
  logic [10:0] txShift;
  logic [10:0] next_txShift;
  logic [3:0] txBitsLeft;
  logic [3:0] next_txBitsLeft;
  logic txEnPrev;
  logic preamblePending;
  logic next_preamblePending;
  logic breakTail;
  logic next_breakTail;
  logic inBreak;
  logic next_inBreak;
  logic [3:0] frameLen;
  logic [8:0] txChar;
  logic preambleDue;
  logic tailDue;
  logic loadSlot;
  logic next_txdOut;
  logic next_txdOeN;
  logic next_txCompleteFlag;

  always_comb begin
    frameLen = cfg.charLen9 ? 4'(ast_pkg::FRAME_BITS_9) : 4'(ast_pkg::FRAME_BITS_8);
    txChar = {txNinthBit, txData};
    if (cfg.parityEn) begin
      if (cfg.charLen9) begin
        txChar[8] = ^txData ^ cfg.parityOdd;
      end else begin
        txChar[7] = ^txData[6:0] ^ cfg.parityOdd;
      end
    end
    next_txState = txState;
    next_txShift = txShift;
    next_txBitsLeft = txBitsLeft;
    next_preamblePending = preamblePending;
    next_breakTail = breakTail;
    next_inBreak = inBreak;
    txHandOver = 1'b0;
    // an enable edge on the load tick itself still gets its preamble
    preambleDue = preamblePending || (txEnable && !txEnPrev);
    tailDue = breakTail;
    loadSlot = 1'b0;
    if (txEnable && !txEnPrev) begin
      next_preamblePending = 1'b1;
    end
    unique case (txState)
      ast_pkg::TX_IDLE: begin
        loadSlot = txTick && txEnable;
      end
      ast_pkg::TX_SHIFT: begin
        if (txTick) begin
          next_txShift = {1'b1, txShift[10:1]};
          next_txBitsLeft = txBitsLeft - 4'h1;
          if (txBitsLeft == 4'h1) begin
            // next character follows straight on, breaks run back to back
            loadSlot = txEnable;
            tailDue = breakTail || (inBreak && !sendBreak);
            next_breakTail = tailDue;
            next_inBreak = 1'b0;
            next_txState = ast_pkg::TX_IDLE;
          end
        end
      end
    endcase
    if (loadSlot) begin
      if (preambleDue) begin
        next_txShift = ast_pkg::RST_SHIFT;
        next_txBitsLeft = frameLen;
        next_preamblePending = 1'b0;
        next_txState = ast_pkg::TX_SHIFT;
      end else if (sendBreak) begin
        next_txShift = 11'h000;
        next_txBitsLeft = frameLen;
        next_inBreak = 1'b1;
        next_txState = ast_pkg::TX_SHIFT;
      end else if (tailDue) begin
        next_txShift = ast_pkg::RST_SHIFT;
        next_txBitsLeft = 4'h1;
        next_breakTail = 1'b0;
        next_txState = ast_pkg::TX_SHIFT;
      end else if (!txBufferEmptyFlag) begin
        if (cfg.charLen9) begin
          next_txShift = {1'b1, txChar, 1'b0};
        end else begin
          next_txShift = {2'b11, txChar[7:0], 1'b0};
        end
        next_txBitsLeft = frameLen;
        txHandOver = 1'b1;
        next_txState = ast_pkg::TX_SHIFT;
      end
    end
    next_txdOut = (txState == ast_pkg::TX_SHIFT) ? txShift[0] : ast_pkg::RST_LINE;
    next_txdOeN = !(txEnable || (txState == ast_pkg::TX_SHIFT));
    next_txCompleteFlag = (txState == ast_pkg::TX_IDLE) && txBufferEmptyFlag && !preamblePending;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      txState <= ast_pkg::TX_IDLE;
      txShift <= ast_pkg::RST_SHIFT;
      txBitsLeft <= 4'h0;
      txEnPrev <= 1'b0;
      preamblePending <= 1'b0;
      breakTail <= 1'b0;
      inBreak <= 1'b0;
      txdOut <= ast_pkg::RST_LINE;
      txdOeN <= 1'b1;
      txCompleteFlag <= ast_pkg::RST_TX_DONE;
    end else begin
      txState <= next_txState;
      txShift <= next_txShift;
      txBitsLeft <= next_txBitsLeft;
      txEnPrev <= txEnable;
      preamblePending <= next_preamblePending;
      breakTail <= next_breakTail;
      inBreak <= next_inBreak;
      txdOut <= next_txdOut;
      txdOeN <= next_txdOeN;
      txCompleteFlag <= next_txCompleteFlag;
    end
  end

  // ---------------------------------------------
  // receive pin filter
  // ---------------------------------------------
  logic [2:0] rxSync;
  logic rxLevel;
  logic rxLevelPrev;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rxSync <= 3'h7;
      rxLevel <= ast_pkg::RST_LINE;
      rxLevelPrev <= ast_pkg::RST_LINE;
    end else begin
      rxSync <= {rxSync[1:0], rxdIn};
      if (rxSync[1] == rxSync[2]) begin
        rxLevel <= rxSync[2];
      end
      rxLevelPrev <= rxLevel;
    end
  end

  // ---------------------------------------------
  // receive shifter, 16 samples per bit
  // ---------------------------------------------
  ast_pkg::ast_rx_state_t rxState;
  ast_pkg::ast_rx_state_t next_rxState;
  logic [3:0] rtPhase;
  logic [3:0] next_rtPhase;
  logic [2:0] samples;
  logic [2:0] next_samples;
  logic [8:0] rxShift;
  logic [8:0] next_rxShift;
  logic [3:0] rxBitIdx;
  logic [3:0] next_rxBitIdx;
  logic rxNoise;
  logic next_rxNoise;
  logic pushValid;
  logic pushReady;
  ast_pkg::ast_rx_word_t pushWord;
  logic rxBit;
  logic [3:0] dataBits;
  logic rxParity;
  logic next_overrun;

  always_comb begin
    dataBits = cfg.charLen9 ? 4'h9 : 4'h8;
    rxBit = maj3(samples);
    next_rxState = rxState;
    next_rtPhase = rtPhase;
    next_samples = samples;
    next_rxShift = rxShift;
    next_rxBitIdx = rxBitIdx;
    next_rxNoise = rxNoise;
    pushValid = 1'b0;
    rxParity = ^rxShift ^ cfg.parityOdd;
    pushWord.data = rxShift[7:0];
    pushWord.ninth = cfg.charLen9 ? rxShift[8] : 1'b0;
    pushWord.fe = !maj3(samples);
    pushWord.nf = rxNoise || noisy3(samples);
    pushWord.pe = cfg.parityEn && rxParity;
    if (rxState == ast_pkg::RX_IDLE) begin
      if (rxPinOwned && rxLevelPrev && !rxLevel) begin
        next_rxState = ast_pkg::RX_START;
        next_rtPhase = 4'h1;
        next_samples = 3'h0;
        next_rxNoise = 1'b0;
        next_rxShift = 9'h000;
        next_rxBitIdx = 4'h0;
      end
    end else if (rtTick) begin
      next_rtPhase = rtPhase + 4'h1;
      if (rxState == ast_pkg::RX_START) begin
        if (next_rtPhase == ast_pkg::RT_START_A) begin
          next_samples[0] = rxLevel;
        end
        if (next_rtPhase == ast_pkg::RT_START_B) begin
          next_samples[1] = rxLevel;
        end
        if (next_rtPhase == ast_pkg::RT_START_C) begin
          next_samples[2] = rxLevel;
          next_rxNoise = noisy3({rxLevel, samples[1:0]});
          if (maj3({rxLevel, samples[1:0]})) begin
            next_rxState = ast_pkg::RX_IDLE;
          end
        end
      end else begin
        if (next_rtPhase == ast_pkg::RT_DATA_A) begin
          next_samples[0] = rxLevel;
        end
        if (next_rtPhase == ast_pkg::RT_DATA_B) begin
          next_samples[1] = rxLevel;
        end
        if (next_rtPhase == ast_pkg::RT_DATA_C) begin
          next_samples[2] = rxLevel;
        end
      end
      if (rtPhase == ast_pkg::RT_LAST) begin
        unique case (rxState)
          ast_pkg::RX_START: begin
            next_rxState = ast_pkg::RX_DATA;
          end
          ast_pkg::RX_DATA: begin
            next_rxShift[rxBitIdx] = rxBit;
            next_rxNoise = rxNoise || noisy3(samples);
            next_rxBitIdx = rxBitIdx + 4'h1;
            if (rxBitIdx == dataBits - 4'h1) begin
              next_rxState = ast_pkg::RX_STOP;
            end
          end
          ast_pkg::RX_STOP: begin
            pushValid = 1'b1;
            next_rxState = ast_pkg::RX_IDLE;
          end
          default: begin
            next_rxState = ast_pkg::RX_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rxState <= ast_pkg::RX_IDLE;
      rtPhase <= 4'h0;
      samples <= 3'h0;
      rxShift <= 9'h000;
      rxBitIdx <= 4'h0;
      rxNoise <= 1'b0;
    end else begin
      rxState <= next_rxState;
      rtPhase <= next_rtPhase;
      samples <= next_samples;
      rxShift <= next_rxShift;
      rxBitIdx <= next_rxBitIdx;
      rxNoise <= next_rxNoise;
    end
  end

  // ---------------------------------------------
  // receive buffer and data register
  // ---------------------------------------------
  logic popValid;
  logic popReady;
  ast_pkg::ast_rx_word_t popWord;
  logic rxArm;
  logic next_rxArm;
  logic next_rxFullFlag;
  logic [7:0] next_rxData;
  logic next_rxNinthBit;
  logic next_framingErrFlag;
  logic next_parityErrFlag;
  logic next_noiseFlag;
  logic rxClear;

  ast_skid_buf #(.WIDTH($bits(ast_pkg::ast_rx_word_t)), .DEPTH(2)) rxBuf (
    .clock(clock),
    .nrst(nrst),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushWord),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popWord)
  );

  always_comb begin
    rxClear = dataLowRead && rxArm;
    popReady = !rxFullFlag || rxClear;
    next_rxArm = rxArm;
    next_rxFullFlag = rxFullFlag;
    next_rxData = rxData;
    next_rxNinthBit = rxNinthBit;
    next_framingErrFlag = framingErrFlag;
    next_parityErrFlag = parityErrFlag;
    next_noiseFlag = noiseFlag;
    next_overrun = overrunFlag;
    if (statusRead && rxFullFlag) begin
      next_rxArm = 1'b1;
    end
    if (dataLowRead) begin
      next_rxArm = 1'b0;
    end
    if (rxClear) begin
      next_rxFullFlag = 1'b0;
      next_overrun = 1'b0;
    end
    if (popValid && popReady) begin
      next_rxData = popWord.data;
      next_rxNinthBit = popWord.ninth;
      next_framingErrFlag = popWord.fe;
      next_parityErrFlag = popWord.pe;
      next_noiseFlag = popWord.nf;
      next_rxFullFlag = 1'b1;
    end
    if (pushValid && !pushReady) begin
      next_overrun = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rxArm <= 1'b0;
      rxFullFlag <= 1'b0;
      rxData <= 8'h00;
      rxNinthBit <= 1'b0;
      framingErrFlag <= 1'b0;
      parityErrFlag <= 1'b0;
      noiseFlag <= 1'b0;
      overrunFlag <= 1'b0;
      rxActiveFlag <= 1'b0;
      rxPinOwned <= 1'b0;
      txIrq <= 1'b0;
      rxIrq <= 1'b0;
    end else begin
      rxArm <= next_rxArm;
      rxFullFlag <= next_rxFullFlag;
      rxData <= next_rxData;
      rxNinthBit <= next_rxNinthBit;
      framingErrFlag <= next_framingErrFlag;
      parityErrFlag <= next_parityErrFlag;
      noiseFlag <= next_noiseFlag;
      overrunFlag <= next_overrun;
      rxActiveFlag <= (rxState != ast_pkg::RX_IDLE);
      rxPinOwned <= txEnable || (txState == ast_pkg::TX_SHIFT);
      txIrq <= next_txBufferEmptyFlag && txEmptyIrqEn;
      rxIrq <= next_rxFullFlag && rxFullIrqEn;
    end
  end

endmodule

// >>> tb/ast_transceiver_properties.sv
`timescale 1ns/1ps
module ast_transceiver_properties (
  input wire logic clock,
  input wire logic nrst,
  input wire logic txEnable,
  input wire logic statusRead,
  input wire logic dataLowWrite,
  input wire logic txEmptyIrqEn,
  input wire logic rxFullIrqEn,
  input wire logic txdOut,
  input wire logic txdOeN,
  input wire logic txBufferEmptyFlag,
  input wire logic txCompleteFlag,
  input wire logic rxFullFlag,
  input wire logic framingErrFlag,
  input wire logic txIrq,
  input wire logic rxIrq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  idle_line_high_a: assert property (txCompleteFlag && $past(txCompleteFlag) |-> txdOut)
    else $error("txd low while idle");
  pin_taken_a: assert property ($rose(txEnable) |-> ##[1:2] !txdOeN)
    else $error("pin not driven after enable");
  pin_released_a: assert property (!txEnable && $past(!txEnable) && txCompleteFlag |-> ##[0:2] txdOeN)
    else $error("pin kept after disable");
  empty_clear_a: assert property ($past(statusRead && txBufferEmptyFlag && !dataLowWrite, 2) && !$past(dataLowWrite)
    && dataLowWrite && !txEnable |-> ##1 !txBufferEmptyFlag)
    else $error("empty flag not cleared");
  empty_fall_cause_a: assert property ($fell(txBufferEmptyFlag) |-> $past(dataLowWrite) || $past(dataLowWrite, 2))
    else $error("empty flag cleared without write");
  handover_busy_a: assert property ($rose(txBufferEmptyFlag) |-> !txCompleteFlag)
    else $error("empty set without shifter busy");
  tx_irq_on_a: assert property (txEmptyIrqEn && $past(txEmptyIrqEn) && txBufferEmptyFlag && $past(txBufferEmptyFlag) |-> txIrq)
    else $error("tx irq missing");
  tx_irq_off_a: assert property (!txEmptyIrqEn && $past(!txEmptyIrqEn) |-> !txIrq)
    else $error("tx irq while masked");
  rx_irq_on_a: assert property (rxFullIrqEn && $past(rxFullIrqEn) && rxFullFlag && $past(rxFullFlag) |-> rxIrq)
    else $error("rx irq missing");
  fe_with_full_a: assert property ($rose(framingErrFlag) |-> rxFullFlag)
    else $error("framing error without full");
endmodule

bind ast_transceiver ast_transceiver_properties u_props (.clock(clock), .nrst(nrst), .txEnable(txEnable),
  .statusRead(statusRead), .dataLowWrite(dataLowWrite), .txEmptyIrqEn(txEmptyIrqEn), .rxFullIrqEn(rxFullIrqEn),
  .txdOut(txdOut), .txdOeN(txdOeN), .txBufferEmptyFlag(txBufferEmptyFlag), .txCompleteFlag(txCompleteFlag),
  .rxFullFlag(rxFullFlag), .framingErrFlag(framingErrFlag), .txIrq(txIrq), .rxIrq(rxIrq));

// >>> tb/ast_remote_model.sv
`timescale 1ns/1ps
module ast_remote_model #(
  parameter int BIT = 32
) (
  input wire logic clock,
  input wire logic txd,
  input wire logic txdOeN,
  input wire logic nine,
  output logic rxd
);
  logic [9:0] rq[$];
  logic [9:0] w;
  logic line;
  // released pin is pulled up
  assign line = txdOeN ? 1'b1 : txd;
  initial rxd = 1'b1;
  task automatic sendFrame(input logic [9:0] bits, input int n);
    rxd <= 1'b0;
    repeat (BIT) @(negedge clock);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (BIT) @(negedge clock);
    end
    rxd <= 1'b1;
    repeat (BIT) @(negedge clock);
  endtask
  always begin
    @(negedge line);
    repeat (BIT / 2) @(posedge clock);
    if (line == 1'b0) begin
      w = '0;
      for (int i = 0; i < (nine ? 10 : 9); i++) begin
        repeat (BIT) @(posedge clock);
        w[i] = line;
      end
      rq.push_back(w);
    end
  end
endmodule

// >>> tb/async_serial_transceiver_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
`define WAIT(c) begin for (int g = 0; g < 20000 && !(c); g++) @(negedge clock); \
  if (!(c)) begin fail_count++; $display("MISMATCH wait exp 1 got 0"); end end
module async_serial_transceiver_tb;
  localparam int DIV = 2;
  localparam int BIT = 16 * DIV;
  logic clock = 0, nrst = 0, txEnable = 0, sendBreak = 0, txEmptyIrqEn = 0, rxFullIrqEn = 0;
  logic statusRead = 0, dataLowWrite = 0, dataHighWrite = 0, dataLowRead = 0, txNinthIn = 0, rxdIn;
  logic [7:0] txDataIn = 0, rxData;
  ast_pkg::ast_cfg_t cfg = '0;
  logic txdOut, txdOeN, rxPinOwned, txBufferEmptyFlag, txCompleteFlag, rxFullFlag, framingErrFlag;
  logic parityErrFlag, noiseFlag, overrunFlag, rxActiveFlag, rxNinthBit, txIrq, rxIrq;
  int fail_count = 0, comparisons = 0, cnt, nb;
  logic [12:0] baudDivisor = 13'(DIV);
  integer seed;
  logic [7:0] dq [4];
  ast_pkg::ast_cfg_t modes [4] = '{3'b000, 3'b100, 3'b010, 3'b111};
  ast_transceiver dut (.clock, .nrst, .cfg, .baudDivisor, .txEnable, .sendBreak, .txEmptyIrqEn,
    .rxFullIrqEn, .statusRead, .dataLowWrite, .dataHighWrite, .dataLowRead, .txDataIn, .txNinthIn, .rxdIn,
    .txdOut, .txdOeN, .rxPinOwned, .txBufferEmptyFlag, .txCompleteFlag, .rxFullFlag, .framingErrFlag,
    .parityErrFlag, .noiseFlag, .overrunFlag, .rxActiveFlag, .rxData, .rxNinthBit, .txIrq, .rxIrq);
  ast_remote_model #(.BIT(BIT)) m (.clock, .txd(txdOut), .txdOeN, .nine(cfg.charLen9), .rxd(rxdIn));
  initial forever #20 clock = ~clock;
  function automatic logic [9:0] expTx(ast_pkg::ast_cfg_t c, logic [7:0] d, logic t8);
    logic [9:0] v;
    v = c.charLen9 ? {1'b1, t8, d} : {2'b01, d};
    if (c.parityEn && c.charLen9) v[8] = ^d ^ c.parityOdd;
    if (c.parityEn && !c.charLen9) v[7] = ^d[6:0] ^ c.parityOdd;
    return v;
  endfunction
  task automatic strobe(ref logic s);
    s = 1;
    @(negedge clock);
    s = 0;
    @(negedge clock);
  endtask
  task automatic txWord(input logic [7:0] d);
    `WAIT(txBufferEmptyFlag === 1'b1)
    strobe(statusRead);
    txDataIn = d;
    strobe(dataLowWrite);
  endtask
  task automatic rxWord(input logic [9:0] f, input logic fe);
    m.sendFrame(f, cfg.charLen9 ? 10 : 9);
    `WAIT(rxFullFlag === 1'b1)
    `CHK("rxData", f[7:0], rxData)
    `CHK("rxNinth", cfg.charLen9 & f[8], rxNinthBit)
    `CHK("fe", fe, framingErrFlag)
    `CHK("pe", 1'b0, parityErrFlag)
    `CHK("nf", 1'b0, noiseFlag)
    `CHK("active", 1'b0, rxActiveFlag)
    strobe(statusRead);
    strobe(dataLowRead);
  endtask
  task automatic end_sim;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    fail_count++;
    end_sim();
  end
  initial begin
    seed = 32'h6b0c60f6;
    repeat (2) @(negedge clock);
    nrst = 1;
    `CHK("empty", 1'b1, txBufferEmptyFlag)
    `CHK("oeN", 1'b1, txdOeN)
    dq[0] = 8'hA5;
    txDataIn = dq[0];
    strobe(dataLowWrite);
    `CHK("noArm", 1'b1, txBufferEmptyFlag)
    txWord(dq[0]);
    `CHK("cleared", 1'b0, txBufferEmptyFlag)
    txNinthIn = 1;
    strobe(dataHighWrite);
    for (int k = 0; k < 4; k++) begin
      cfg = modes[k];
      nb = cfg.charLen9 ? 11 : 10;
      txEmptyIrqEn = k[0];
      rxFullIrqEn = !k[0];
      for (int j = 0; j < 4; j++) if (k > 0 || j > 0) dq[j] = $random(seed);
      txEnable = 1;
      if (k > 0) txWord(dq[0]);
      for (cnt = 0; txdOut !== 1'b0 && cnt < 2000; cnt++) @(negedge clock);
      `CHK("preamble", 1'b1, cnt + 8 >= nb * BIT && cnt < (nb + 2) * BIT)
      txWord(dq[1]);
      txWord(dq[2]);
      `WAIT(m.rq.size() == 3)
      for (int j = 0; j < 3; j++) `CHK("txFrame", expTx(cfg, dq[j], 1'b1), m.rq[j])
      m.rq.delete();
      rxWord(expTx(cfg, dq[1], dq[2][0]), 1'b0);
      `WAIT(txCompleteFlag === 1'b1)
      txEnable = 0;
      repeat (4) @(negedge clock);
    end
    cfg = modes[0];
    txEnable = 1;
    rxWord(10'h000, 1'b1);
    for (int j = 0; j < 4; j++) m.sendFrame(expTx(cfg, dq[j], 1'b0), 9);
    `CHK("overrun", 1'b1, overrunFlag)
    for (int j = 0; j < 3; j++) begin
      `CHK("rxBuf", dq[j], rxData)
      strobe(statusRead);
      strobe(dataLowRead);
    end
    txWord(8'h3C);
    `WAIT(txdOut === 1'b0)
    txWord(8'hC3);
    txEnable = 0;
    repeat (12 * BIT) @(negedge clock);
    `CHK("inflight", 1, m.rq.size())
    `CHK("pending", 1'b0, txBufferEmptyFlag)
    `CHK("released", 1'b1, txdOeN)
    `CHK("rxOwned", 1'b0, rxPinOwned)
    m.rq.delete();
    txEnable = 1;
    sendBreak = 1;
    repeat (30 * BIT) @(negedge clock);
    `CHK("break", 1'b0, txdOut)
    sendBreak = 0;
    for (cnt = 0; txdOut !== 1'b1 && cnt < 2000; cnt++) @(negedge clock);
    `CHK("breakEnd", 1'b1, cnt <= 12 * BIT)
    `WAIT(txdOut === 1'b0)
    txEnable = 0;
    @(negedge clock);
    txEnable = 1;
    txWord(8'h5A);
    repeat (10 * BIT) @(negedge clock);
    for (cnt = 0; txdOut !== 1'b0 && cnt < 2000; cnt++) @(negedge clock);
    `CHK("idleChar", 1'b1, cnt >= 9 * BIT)
    end_sim();
  end
endmodule
